// [ubf_top.v]
// Purpose: Uniform block layout engine, link check and member fetch
// Assumes: Descriptors arrive one per cycle in declaration order
// Notes: Struct nesting up to four levels deep
//
// Functional notes
// - Booleans read as one word; nonzero is true, zero is false.
// - Int, uint and float scalars read as one word at their offset.
// - Vectors read N consecutive words, X component lowest.
// - Column-major matrix read as column vectors separated by constant stride.
// - Row-major matrix read as row vectors separated by constant stride.
// - Array elements in index order with one constant array stride.
// - Without packed layout, offsets are chosen here and reported.
// - Link fails unless every shader's block declaration is identical.
// - Packed members increase in order, each at its rounded-up aligned offset.
// - First member starts at structure offset; later ones after previous member.
// - Alignment: scalar N, two-vector 2N, three- and four-vector 4N.
// - Scalar and vector arrays align and stride at four-vector alignment.
// - Column-major matrix is an array of column vectors.
// - Row-major matrix is an array of row vectors.
// - Structure aligns to four-vector alignment; members placed recursively.
// - Structure array is consecutive structure elements in index order.
// - Row order indicator is one only for row-major matrices.
`timescale 1ns/100ps
`include "ubf_defines.vh"

module ubf_top (
    // Clock and reset
    input wire clk,
    input wire nrst,
    // Member declarations
    input wire decl_valid,
    input wire [2:0] decl_kind,
    input wire [1:0] decl_type,
    input wire [2:0] decl_comps,
    input wire [2:0] decl_cols,
    input wire [2:0] decl_rows,
    input wire decl_row_major,
    input wire [7:0] decl_array_len,
    input wire decl_packed,
    input wire decl_repeat,
    // Layout report
    output reg lay_valid,
    output reg [15:0] lay_offset,
    output reg [15:0] lay_array_stride,
    output reg [15:0] lay_matrix_stride,
    output reg row_order_indicator,
    output reg [15:0] lay_block_size,
    output reg lay_block_done,
    output reg lay_nest_error,
    // Link check
    output reg link_done,
    output reg link_fail,
    // Fetch request
    input wire req_valid,
    output wire req_ready,
    input wire [15:0] req_offset,
    input wire [15:0] req_array_stride,
    input wire [15:0] req_matrix_stride,
    input wire [7:0] req_elem,
    input wire [2:0] req_vec,
    input wire [2:0] req_comps,
    input wire [1:0] req_type,
    // Buffer memory
    output wire mem_rd,
    output wire [15:0] mem_addr,
    input wire [31:0] mem_rdata,
    input wire mem_rvalid,
    // Fetched components
    output wire out_valid,
    output wire [31:0] out_data,
    output wire [2:0] out_comp,
    output wire out_last
);
    // ==========================================
    // Reset release
    reg rst_meta;
    reg rst_n;

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ==========================================
    // Member geometry
    wire [4:0] mem_align;
    wire [15:0] mem_astride;
    wire [15:0] mem_mstride;
    wire [15:0] mem_size;

    ubf_align u_align (
        .kind(decl_kind),
        .comps(decl_comps),
        .cols(decl_cols),
        .rows(decl_rows),
        .row_major(decl_row_major),
        .array_len(decl_array_len),
        .packed_layout(decl_packed),
        .base_align(mem_align),
        .array_stride(mem_astride),
        .matrix_stride(mem_mstride),
        .total_size(mem_size)
    );

    // ==========================================
    // Layout state
    reg [15:0] cur;
    reg [2:0] depth;
    reg [15:0] stk_start [0:`UBF_STACK_DEPTH-1];
    reg [7:0] stk_len [0:`UBF_STACK_DEPTH-1];
    reg [4:0] stk_align [0:`UBF_STACK_DEPTH-1];
    integer i;

    reg [15:0] next_aligned;
    reg [15:0] struct_start;
    reg [7:0] struct_len;
    reg [4:0] struct_align;
    reg [15:0] struct_size;
    reg [15:0] struct_elem;
    reg [23:0] struct_total;
    reg [4:0] struct_open_align;
    reg [15:0] struct_open_ofs;
    reg [15:0] block_end;
    wire [1:0] top_idx;

    assign top_idx = depth[1:0] - 2'h1;

    function [15:0] round_up;
        input [15:0] value;
        input [4:0] align;
        begin
            round_up = (value + {11'h000, align} - 16'h0001) & ~({11'h000, align} - 16'h0001);
        end
    endfunction

    always @* begin
        next_aligned = round_up(cur, mem_align);
        struct_open_align = decl_packed ? `UBF_FOUR_FLOAT_VECTOR_ALIGN : `UBF_SCALAR_BYTES;
        struct_open_ofs = round_up(cur, struct_open_align);
        struct_start = stk_start[top_idx];
        struct_len = stk_len[top_idx];
        struct_align = stk_align[top_idx];
        struct_size = cur - struct_start;
        // Padding at the end of each structure element
        struct_elem = round_up(struct_size, struct_align);
        struct_total = struct_elem * ((struct_len == 8'h00) ? 8'h01 : struct_len);
        block_end = decl_packed ? round_up(cur, `UBF_FOUR_FLOAT_VECTOR_ALIGN) : cur;
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= 16'h0000;
            depth <= 3'h0;
            for (i = 0; i < `UBF_STACK_DEPTH; i = i + 1) begin
                stk_start[i] <= 16'h0000;
                stk_len[i] <= 8'h00;
                stk_align[i] <= 5'h00;
            end
            lay_valid <= 1'b0;
            lay_offset <= 16'h0000;
            lay_array_stride <= 16'h0000;
            lay_matrix_stride <= 16'h0000;
            row_order_indicator <= 1'b0;
            lay_block_size <= 16'h0000;
            lay_block_done <= 1'b0;
            lay_nest_error <= 1'b0;
        end else begin
            lay_valid <= 1'b0;
            lay_block_done <= 1'b0;
            if (decl_valid) begin
                case (decl_kind)
                    `UBF_KIND_SCALAR, `UBF_KIND_VECTOR, `UBF_KIND_MATRIX: begin
                        lay_valid <= 1'b1;
                        lay_offset <= next_aligned;
                        lay_array_stride <= mem_astride;
                        lay_matrix_stride <= mem_mstride;
                        row_order_indicator <= (decl_kind == `UBF_KIND_MATRIX) &&
                            decl_row_major;
                        // Next base offset follows the last unit consumed
                        cur <= next_aligned + mem_size;
                    end
                    `UBF_KIND_STRUCT_BEGIN: begin
                        lay_valid <= 1'b1;
                        lay_offset <= struct_open_ofs;
                        lay_array_stride <= 16'h0000;
                        lay_matrix_stride <= 16'h0000;
                        row_order_indicator <= 1'b0;
                        if (depth == `UBF_STACK_DEPTH) begin
                            lay_nest_error <= 1'b1;
                        end else begin
                            stk_start[depth[1:0]] <= struct_open_ofs;
                            stk_len[depth[1:0]] <= decl_array_len;
                            stk_align[depth[1:0]] <= struct_open_align;
                            depth <= depth + 3'h1;
                            cur <= struct_open_ofs;
                        end
                    end
                    `UBF_KIND_STRUCT_END: begin
                        if (depth == 3'h0) begin
                            lay_nest_error <= 1'b1;
                        end else begin
                            lay_valid <= 1'b1;
                            lay_offset <= struct_start;
                            lay_array_stride <= (struct_len == 8'h00) ? 16'h0000 :
                                struct_elem;
                            lay_matrix_stride <= 16'h0000;
                            row_order_indicator <= 1'b0;
                            // Member after the structure rounds up to its alignment
                            cur <= struct_start + struct_total[15:0];
                            depth <= depth - 3'h1;
                        end
                    end
                    `UBF_KIND_BLOCK_END: begin
                        lay_block_done <= 1'b1;
                        lay_block_size <= block_end;
                        lay_nest_error <= (depth != 3'h0);
                        cur <= 16'h0000;
                        depth <= 3'h0;
                    end
                    default: begin
                        lay_nest_error <= 1'b1;
                    end
                endcase
            end
        end
    end

    // ==========================================
    // Declaration signature for the link check
    reg [31:0] sig;
    reg [31:0] ref_sig;
    reg ref_held;
    wire [31:0] desc_word;
    wire [31:0] sig_step;

    assign desc_word = {8'h00, decl_packed, decl_array_len, decl_row_major, decl_rows,
        decl_cols, decl_comps, decl_type, decl_kind};
    assign sig_step = {sig[30:0], sig[31]} ^ desc_word;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sig <= `UBF_SIG_RESET;
            ref_sig <= `UBF_SIG_RESET;
            ref_held <= 1'b0;
            link_done <= 1'b0;
            link_fail <= 1'b0;
        end else begin
            link_done <= 1'b0;
            if (decl_valid) begin
                if (decl_kind == `UBF_KIND_BLOCK_END) begin
                    sig <= `UBF_SIG_RESET;
                    if (!decl_repeat) begin
                        ref_sig <= sig_step;
                        ref_held <= 1'b1;
                        link_fail <= 1'b0;
                    end else begin
                        link_done <= 1'b1;
                        // Any difference, layout choice included, rejects the link
                        if (!ref_held || sig_step != ref_sig) begin
                            link_fail <= 1'b1;
                        end
                    end
                end else begin
                    sig <= sig_step;
                end
            end
        end
    end

    // ==========================================
    // Member fetch
    ubf_fetch u_fetch (
        .clk(clk),
        .rst_n(rst_n),
        .req_valid(req_valid),
        .req_ready(req_ready),
        .req_offset(req_offset),
        .req_array_stride(req_array_stride),
        .req_matrix_stride(req_matrix_stride),
        .req_elem(req_elem),
        .req_vec(req_vec),
        .req_comps(req_comps),
        .req_type(req_type),
        .mem_rd(mem_rd),
        .mem_addr(mem_addr),
        .mem_rdata(mem_rdata),
        .mem_rvalid(mem_rvalid),
        .out_valid(out_valid),
        .out_data(out_data),
        .out_comp(out_comp),
        .out_last(out_last)
    );
endmodule // ubf_top

// [ubf_defines.vh]
// Purpose: Shared constants of the uniform block layout and fetch block
// Assumes: One byte per basic machine unit, four-byte scalars
// Notes: Definitions only
`ifndef UBF_DEFINES_VH
`define UBF_DEFINES_VH

// ==========================================
// Units and alignments
`define UBF_SCALAR_BYTES 5'h04
`define UBF_VEC2_ALIGN 5'h08
`define UBF_FOUR_FLOAT_VECTOR_ALIGN 5'h10
`define UBF_OFS_W 16

// ==========================================
// Descriptor kinds
`define UBF_KIND_SCALAR 3'h0
`define UBF_KIND_VECTOR 3'h1
`define UBF_KIND_MATRIX 3'h2
`define UBF_KIND_STRUCT_BEGIN 3'h3
`define UBF_KIND_STRUCT_END 3'h4
`define UBF_KIND_BLOCK_END 3'h5

// ==========================================
// Scalar base types
`define UBF_TYPE_BOOL 2'h0
`define UBF_TYPE_INT 2'h1
`define UBF_TYPE_UINT 2'h2
`define UBF_TYPE_FLOAT 2'h3

// ==========================================
// Nesting and reset values
`define UBF_STACK_DEPTH 4
`define UBF_SIG_RESET 32'h00000000

`endif

// [ubf_align.v]
// Purpose: Base alignment, strides and size of one member descriptor
// Assumes: Scalars of four units; array length zero means not an array
// Notes: Pure combinational helper of the layout engine
`timescale 1ns/100ps
`include "ubf_defines.vh"

module ubf_align (
    // Descriptor
    input wire [2:0] kind,
    input wire [2:0] comps,
    input wire [2:0] cols,
    input wire [2:0] rows,
    input wire row_major,
    input wire [7:0] array_len,
    input wire packed_layout,
    // Results
    output reg [4:0] base_align,
    output reg [15:0] array_stride,
    output reg [15:0] matrix_stride,
    output reg [15:0] total_size
);
    reg [2:0] comp_n;
    reg [2:0] vec_n;
    reg [4:0] elem_bytes;
    reg [4:0] vec_stride;
    reg [15:0] elem_size;
    reg [23:0] arr_total;

    always @* begin
        comp_n = 3'h1;
        vec_n = 3'h1;
        if (kind == `UBF_KIND_VECTOR) begin
            comp_n = comps;
        end else if (kind == `UBF_KIND_MATRIX) begin
            vec_n = row_major ? rows : cols;
            comp_n = row_major ? cols : rows;
        end
        elem_bytes = {comp_n, 2'b00};
        // Packed: natural alignment per scalar and vector width; unpacked: scalar alignment
        if (!packed_layout) begin
            base_align = `UBF_SCALAR_BYTES;
        end else if (kind == `UBF_KIND_SCALAR) begin
            base_align = `UBF_SCALAR_BYTES;
        end else if (kind == `UBF_KIND_VECTOR && comps == 3'h2) begin
            base_align = `UBF_VEC2_ALIGN;
        end else begin
            base_align = `UBF_FOUR_FLOAT_VECTOR_ALIGN;
        end
        if (packed_layout && array_len != 8'h00) begin
            base_align = `UBF_FOUR_FLOAT_VECTOR_ALIGN;
        end
        vec_stride = packed_layout ? `UBF_FOUR_FLOAT_VECTOR_ALIGN : elem_bytes;
        matrix_stride = 16'h0000;
        elem_size = {11'h000, elem_bytes};
        if (kind == `UBF_KIND_MATRIX) begin
            matrix_stride = {11'h000, vec_stride};
            elem_size = {13'h0, vec_n} * {11'h000, vec_stride};
        end
        array_stride = 16'h0000;
        if (array_len != 8'h00) begin
            if (kind == `UBF_KIND_MATRIX || !packed_layout) begin
                array_stride = elem_size;
            end else begin
                array_stride = {11'h000, `UBF_FOUR_FLOAT_VECTOR_ALIGN};
            end
        end
        arr_total = array_len * array_stride;
        total_size = (array_len != 8'h00) ? arr_total[15:0] : elem_size;
    end
endmodule // ubf_align

// [ubf_fetch.v]
// Purpose: Reads the components of one member vector out of buffer memory
// Assumes: Memory answers each read with rvalid one or more cycles later
// Notes: Address is offset + element * array stride + vector * matrix stride
`timescale 1ns/100ps
`include "ubf_defines.vh"

module ubf_fetch (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Request
    input wire req_valid,
    output reg req_ready,
    input wire [15:0] req_offset,
    input wire [15:0] req_array_stride,
    input wire [15:0] req_matrix_stride,
    input wire [7:0] req_elem,
    input wire [2:0] req_vec,
    input wire [2:0] req_comps,
    input wire [1:0] req_type,
    // Buffer memory
    output reg mem_rd,
    output reg [15:0] mem_addr,
    input wire [31:0] mem_rdata,
    input wire mem_rvalid,
    // Component output
    output reg out_valid,
    output reg [31:0] out_data,
    output reg [2:0] out_comp,
    output reg out_last
);
    localparam ST_IDLE = 2'b00;
    localparam ST_ISSUE = 2'b01;
    localparam ST_WAIT = 2'b10;

    reg [1:0] state;
    reg [2:0] comp_left;
    reg [2:0] comp_idx;
    reg [1:0] cur_type;
    wire [23:0] elem_ofs;
    wire [18:0] vec_ofs;
    wire [15:0] start_addr;

    assign elem_ofs = req_elem * req_array_stride;
    assign vec_ofs = req_vec * req_matrix_stride;
    assign start_addr = req_offset + elem_ofs[15:0] + vec_ofs[15:0];

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            req_ready <= 1'b1;
            mem_rd <= 1'b0;
            mem_addr <= 16'h0000;
            out_valid <= 1'b0;
            out_data <= 32'h00000000;
            out_comp <= 3'h0;
            out_last <= 1'b0;
            comp_left <= 3'h0;
            comp_idx <= 3'h0;
            cur_type <= `UBF_TYPE_UINT;
        end else begin
            out_valid <= 1'b0;
            out_last <= 1'b0;
            mem_rd <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (req_valid && req_comps != 3'h0) begin
                        req_ready <= 1'b0;
                        mem_addr <= start_addr;
                        comp_left <= req_comps;
                        comp_idx <= 3'h0;
                        cur_type <= req_type;
                        state <= ST_ISSUE;
                    end
                end
                ST_ISSUE: begin
                    mem_rd <= 1'b1;
                    state <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (mem_rvalid) begin
                        out_valid <= 1'b1;
                        out_comp <= comp_idx;
                        if (cur_type == `UBF_TYPE_BOOL) begin
                            out_data <= {31'h0, |mem_rdata};
                        end else begin
                            out_data <= mem_rdata;
                        end
                        if (comp_left == 3'h1) begin
                            out_last <= 1'b1;
                            req_ready <= 1'b1;
                            state <= ST_IDLE;
                        end else begin
                            // Next component at the next higher word
                            mem_addr <= mem_addr + {11'h000, `UBF_SCALAR_BYTES};
                            comp_left <= comp_left - 3'h1;
                            comp_idx <= comp_idx + 3'h1;
                            state <= ST_ISSUE;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // ubf_fetch

// [ubf_top_props.sv]
// Purpose: Assertions on the ports of the layout and fetch block
// Assumes: One clock domain, nrst active low
// Notes: Bound to ubf_top
`timescale 1ns/100ps
`include "ubf_defines.vh"
module ubf_chk (
    // Clock and reset
    input wire clk,
    input wire nrst,
    // Layout side
    input wire decl_valid,
    input wire [2:0] decl_kind,
    input wire [2:0] decl_comps,
    input wire [7:0] decl_array_len,
    input wire decl_packed,
    input wire lay_valid,
    input wire [15:0] lay_offset,
    input wire [15:0] lay_array_stride,
    input wire [15:0] lay_matrix_stride,
    input wire row_order_indicator,
    input wire [15:0] lay_block_size,
    input wire lay_block_done,
    // Fetch side
    input wire req_valid,
    input wire req_ready,
    input wire [2:0] req_comps,
    input wire [1:0] req_type,
    input wire mem_rd,
    input wire [31:0] mem_rdata,
    input wire mem_rvalid,
    input wire out_valid,
    input wire [31:0] out_data,
    input wire out_last
);
// ====
// Type of the request and last memory word
reg [1:0] ty;
reg [31:0] dq;
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        ty <= 2'h0;
        dq <= 32'h0;
    end else begin
        if (req_valid && req_ready)
            ty <= req_type;
        if (mem_rvalid)
            dq <= mem_rdata;
    end
end
default clocking @(posedge clk); endclocking
default disable iff (!nrst);
// ====
// Properties
chk_take_read: assert property (
    req_valid && req_ready && req_comps != 3'h0 |-> ##2 mem_rd)
    else $error("read not issued two cycles after request");
chk_bool_word: assert property (
    mem_rvalid && ty == `UBF_TYPE_BOOL |=> out_valid && out_data == {31'h0, dq != 32'h0})
    else $error("boolean word not reduced to one");
chk_word_pass: assert property (
    mem_rvalid && ty != `UBF_TYPE_BOOL |=> out_valid && out_data == dq)
    else $error("fetched word altered");
chk_last_ready: assert property (
    out_valid |-> req_ready == out_last)
    else $error("ready not tied to last component");
chk_vec_align: assert property (
    decl_valid && decl_packed && decl_kind == `UBF_KIND_VECTOR && decl_array_len == 8'h0
    |=> lay_valid && (lay_offset & ($past(decl_comps) == 3'h2 ? 16'h0007 : 16'h000F)) == 16'h0)
    else $error("vector offset misaligned");
chk_scalar_align: assert property (
    decl_valid && decl_kind == `UBF_KIND_SCALAR |=> lay_valid && lay_offset[1:0] == 2'h0)
    else $error("scalar offset misaligned");
chk_arr_stride: assert property (
    decl_valid && decl_packed && decl_array_len != 8'h0 && decl_kind <= `UBF_KIND_VECTOR
    |=> lay_array_stride == 16'h0010)
    else $error("array stride not sixteen");
chk_mat_stride: assert property (
    decl_valid && decl_packed && decl_kind == `UBF_KIND_MATRIX
    |=> lay_matrix_stride == 16'h0010 && lay_offset[3:0] == 4'h0)
    else $error("matrix stride or offset wrong");
chk_row_flag: assert property (
    lay_valid && lay_matrix_stride == 16'h0 |-> !row_order_indicator)
    else $error("row order set on non-matrix");
chk_block_end: assert property (
    decl_valid && decl_kind == `UBF_KIND_BLOCK_END
    |=> lay_block_done && (!$past(decl_packed) || lay_block_size[3:0] == 4'h0))
    else $error("block end report wrong");
endmodule // ubf_chk
bind ubf_top ubf_chk i_ubf_chk (.clk, .nrst, .decl_valid, .decl_kind, .decl_comps,
    .decl_array_len, .decl_packed, .lay_valid, .lay_offset, .lay_array_stride,
    .lay_matrix_stride, .row_order_indicator, .lay_block_size, .lay_block_done,
    .req_valid, .req_ready, .req_comps, .req_type, .mem_rd, .mem_rdata, .mem_rvalid,
    .out_valid, .out_data, .out_last);

// [ubf_mem_model.sv]
// Purpose: Buffer memory behind the fetch port
// Assumes: One outstanding read at a time
// Notes: Latency 2 to 5 cycles from mem_rd to mem_rvalid; data line scrambled while idle
`timescale 1ns/100ps
module ubf_mem_model (
    // Clock and reset
    input wire clk,
    input wire nrst,
    // Read port
    input wire mem_rd,
    input wire [15:0] mem_addr,
    output logic [31:0] mem_rdata,
    output logic mem_rvalid
);
logic pend;
logic [15:0] a;
logic [1:0] cnt;
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        pend <= 1'b0;
        mem_rvalid <= 1'b0;
        mem_rdata <= 32'h0;
    end else begin
        mem_rvalid <= 1'b0;
        mem_rdata <= $urandom;
        if (mem_rd) begin
            pend <= 1'b1;
            a <= mem_addr;
            cnt <= 2'($urandom);
        end else if (pend && cnt != 2'h0) begin
            cnt <= cnt - 2'h1;
        end else if (pend) begin
            pend <= 1'b0;
            mem_rvalid <= 1'b1;
            mem_rdata <= a[3] ? 32'h0 : {~a, a};
        end
    end
end
endmodule // ubf_mem_model

// [uniform_block_layout_fetch_test.sv]
// Purpose: Self-checking bench of the layout and fetch block
// Assumes: Memory word at address a is zero when a[3] is set
// Notes: Expected results queued by the drivers
`timescale 1ns/100ps
`include "ubf_defines.vh"
module uniform_block_layout_fetch_test;
logic clk, nrst, decl_valid, decl_row_major, decl_packed, decl_repeat, req_valid;
logic [2:0] decl_kind, decl_comps, decl_cols, decl_rows, req_vec, req_comps;
logic [1:0] decl_type, req_type;
logic [7:0] decl_array_len, req_elem;
logic [15:0] req_offset, req_array_stride, req_matrix_stride;
wire lay_valid, row_order_indicator, lay_block_done, lay_nest_error, link_done, link_fail;
wire req_ready, mem_rd, mem_rvalid, out_valid, out_last;
wire [15:0] lay_offset, lay_array_stride, lay_matrix_stride, lay_block_size, mem_addr;
wire [31:0] mem_rdata, out_data;
wire [2:0] out_comp;
logic [63:0] lq[$], oq[$], bq[$], fq[$], e;
int bad_count, n_compared, cyc;
ubf_top i_ubf_top (.*);
ubf_mem_model i_ubf_mem_model (.*);
initial begin
    clk = 0;
    forever #5 clk = ~clk;
end
task chk(input [63:0] s, input [63:0] x);
    n_compared++;
    if (s !== x) begin
        bad_count++;
        $display("ERROR t=%0t seen=%h exp=%h", $time, s, x);
    end
endtask
task close_out();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
        $display("ALL CHECKS OK");
    else
        $display("CHECKS NOT OK");
    $finish;
endtask
function automatic logic [31:0] pat(input logic [15:0] a);
    return a[3] ? 32'h0 : {~a, a};
endfunction
// ====
// One descriptor and its expected report
task d(input [2:0] k, c, co, ro, input rm, input [7:0] al, input [15:0] o, a, m);
    @(posedge clk);
    decl_valid <= 1'b1;
    decl_kind <= k;
    decl_comps <= c;
    decl_cols <= co;
    decl_rows <= ro;
    decl_row_major <= rm;
    decl_array_len <= al;
    if (k != `UBF_KIND_BLOCK_END)
        lq.push_back({o, a, m, rm});
endtask
// Full or short block, packed or not, first or repeat copy
task blk(input p, r, s);
    decl_packed <= p;
    decl_repeat <= r;
    d(`UBF_KIND_SCALAR, 0, 0, 0, 0, 0, 0, 0, 0);
    d(`UBF_KIND_VECTOR, 3, 0, 0, 0, 0, p ? 16'h10 : 16'h4, 0, 0);
    if (!s) begin
        d(`UBF_KIND_SCALAR, 0, 0, 0, 0, 0, 16'h1C, 0, 0);
        d(`UBF_KIND_VECTOR, 2, 0, 0, 0, 0, 16'h20, 0, 0);
        d(`UBF_KIND_SCALAR, 0, 0, 0, 0, 2, 16'h30, 16'h10, 0);
        d(`UBF_KIND_MATRIX, 0, 2, 3, 0, 0, 16'h50, 0, 16'h10);
        d(`UBF_KIND_MATRIX, 0, 3, 2, 1, 0, 16'h70, 0, 16'h10);
        d(`UBF_KIND_STRUCT_BEGIN, 0, 0, 0, 0, 2, 16'h90, 0, 0);
        d(`UBF_KIND_SCALAR, 0, 0, 0, 0, 0, 16'h90, 0, 0);
        d(`UBF_KIND_STRUCT_END, 0, 0, 0, 0, 0, 16'h90, 16'h10, 0);
        d(`UBF_KIND_SCALAR, 0, 0, 0, 0, 0, 16'hB0, 0, 0);
    end
    d(`UBF_KIND_BLOCK_END, 0, 0, 0, 0, 0, 0, 0, 0);
    bq.push_back(s ? (p ? 16'h20 : 16'h10) : 16'hC0);
    if (r)
        fq.push_back(!p);
    @(posedge clk);
    decl_valid <= 1'b0;
endtask
// One random fetch request
task automatic f();
    logic [15:0] o, as, a;
    logic [7:0] el;
    logic [2:0] v, n;
    logic [1:0] t;
    logic [31:0] w;
    int i;
    o = 16'($urandom) & 16'hFFFC;
    el = 8'($urandom_range(0, 7));
    as = 16'h10 << $urandom_range(0, 2);
    v = 3'($urandom_range(0, 3));
    n = 3'($urandom_range(1, 4));
    t = 2'($urandom);
    @(posedge clk);
    for (i = 0; i < 60 && req_ready !== 1'b1; i++)
        @(posedge clk);
    req_valid <= 1'b1;
    req_offset <= o;
    req_elem <= el;
    req_array_stride <= as;
    req_matrix_stride <= 16'h10;
    req_vec <= v;
    req_comps <= n;
    req_type <= t;
    @(posedge clk);
    req_valid <= 1'b0;
    for (i = 0; i < n; i++) begin
        a = o + el * as + v * 16'h10 + 16'(4 * i);
        w = pat(a);
        if (t == `UBF_TYPE_BOOL)
            w = {31'h0, w != 32'h0};
        oq.push_back({w, 3'(i), i == n - 1});
    end
endtask
// ====
// Result watcher and cycle limit
always @(posedge clk) begin
    cyc++;
    if (lay_valid) begin
        e = lq.size() ? lq.pop_front() : 'x;
        chk({lay_offset, lay_array_stride, lay_matrix_stride, row_order_indicator}, e);
    end
    if (out_valid) begin
        e = oq.size() ? oq.pop_front() : 'x;
        chk({out_data, out_comp, out_last}, e);
    end
    if (lay_block_done) begin
        e = bq.size() ? bq.pop_front() : 'x;
        chk(lay_block_size, e);
    end
    if (link_done) begin
        e = fq.size() ? fq.pop_front() : 'x;
        chk(link_fail, e);
    end
    if (cyc == 5000) begin
        bad_count++;
        close_out();
    end
end
initial begin
    {nrst, decl_valid, decl_row_major, decl_packed, decl_repeat, req_valid} = 6'h0;
    {decl_kind, decl_comps, decl_cols, decl_rows, req_vec, req_comps} = 18'h0;
    {decl_type, req_type, decl_array_len, req_elem} = 20'h3;
    {req_offset, req_array_stride, req_matrix_stride} = 48'h0;
    void'($urandom(32'hD5D881C4));
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    blk(1, 0, 0);
    blk(1, 1, 0);
    blk(1, 0, 1);
    blk(0, 1, 1);
    // Structure end at depth zero flags a nesting error
    @(posedge clk);
    decl_valid <= 1'b1;
    decl_kind <= `UBF_KIND_STRUCT_END;
    @(posedge clk);
    decl_valid <= 1'b0;
    @(posedge clk);
    chk(lay_nest_error, 1);
    repeat (40) f();
    repeat (40) @(posedge clk);
    chk(lq.size() + oq.size() + bq.size() + fq.size(), 0);
    close_out();
end
endmodule // uniform_block_layout_fetch_test
